//--- residual_ov_pkg.sv
// Purpose: Shared constants and types of the residual overvoltage trip block.
// Assumes: 100 MHz system clock; word-aligned register offsets on a plain port.
// Notes: Magnitudes are in percent of rated voltage with MAG_FRAC fraction bits.
`default_nettype none

package residual_ov_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESHOLD = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Control field positions.
  localparam int CTRL_OPER_BIT = 0;
  localparam int CTRL_START_ONLY_BIT = 1;

  // Interrupt event positions.
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_TRIP_BIT = 1;
  localparam int IRQ_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Setting ranges and values after reset.
  localparam int THR_W = 7;
  localparam logic [THR_W-1:0] THR_MIN = 7'h02;
  localparam logic [THR_W-1:0] THR_MAX = 7'h3C;
  localparam logic [THR_W-1:0] THR_RESET = 7'h1E;
  localparam int DELAY_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 16'hEA60;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0064;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam int MAG_FRAC = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one millisecond tick derived from the clock period.
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic
  {
    OPER_OFF = 1'b0,
    OPER_ON = 1'b1
  } oper_t;

  typedef struct packed
  {
    logic gen_trip;
    logic gen_start;
    logic trip_raw;
    logic start_raw;
  } ov_state_t;

  localparam ov_state_t STATE_RESET = 4'h0;

endpackage

`default_nettype wire

//--- residual_overvoltage_trip.sv
// Purpose: Definite-time residual overvoltage start and trip with register access.
// Assumes: Inputs synchronous to i_clk; magnitude supplied upstream every cycle.
// Notes: Outputs are registered and follow the inputs by one clock edge.
//
// The address map and strobed register access were chosen for this implementation.
`default_nettype none

module residual_overvoltage_trip
  import residual_ov_pkg::*;
#(
  parameter int MAG_W = 16,
  parameter int CYC_PER_MS = MS_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  input wire logic [MAG_W-1:0] i_residual_voltage_magnitude,
  input wire logic i_residual_ov_block_in,
  output logic o_residual_ov_start_raw,
  output logic o_residual_ov_trip_raw,
  output logic o_residual_ov_general_start,
  output logic o_residual_ov_general_trip,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers.
  oper_t oper_ff, nxt_oper;
  logic start_only_ff, nxt_start_only;
  logic [THR_W-1:0] thr_ff, nxt_thr;
  logic [DELAY_W-1:0] delay_ff, nxt_delay;
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;

  always_comb
  begin
    nxt_oper = oper_ff;
    nxt_start_only = start_only_ff;
    nxt_thr = thr_ff;
    nxt_delay = delay_ff;
    nxt_irq_mask = irq_mask_ff;
    if (i_we)
    begin
      unique case (i_addr)
        OFS_CTRL:
        begin
          nxt_oper = oper_t'(i_wdata[CTRL_OPER_BIT]);
          nxt_start_only = i_wdata[CTRL_START_ONLY_BIT];
        end
        OFS_THRESHOLD:
        begin
          // Out-of-range writes saturate to the nearest legal setting.
          if (i_wdata < 32'(THR_MIN))
            nxt_thr = THR_MIN;
          else if (i_wdata > 32'(THR_MAX))
            nxt_thr = THR_MAX;
          else
            nxt_thr = i_wdata[THR_W-1:0];
        end
        OFS_DELAY:
        begin
          if (i_wdata > 32'(DELAY_MAX))
            nxt_delay = DELAY_MAX;
          else
            nxt_delay = i_wdata[DELAY_W-1:0];
        end
        OFS_IRQ_MASK: nxt_irq_mask = i_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      oper_ff <= OPER_ON;
      start_only_ff <= 1'b0;
      thr_ff <= THR_RESET;
      delay_ff <= DELAY_RESET;
      irq_mask_ff <= IRQ_MASK_RESET;
    end
    else
    begin
      oper_ff <= nxt_oper;
      start_only_ff <= nxt_start_only;
      thr_ff <= nxt_thr;
      delay_ff <= nxt_delay;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Characteristic: threshold compare and definite-time counting.
  localparam int PRE_W = $clog2(CYC_PER_MS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);

  logic above;
  logic cond;
  logic [PRE_W-1:0] pre_ff, nxt_pre;
  logic [DELAY_W-1:0] ms_cnt_ff, nxt_ms_cnt;
  ov_state_t state_ff, nxt_state;

  // Only the residual magnitude is compared, against the threshold shifted up by MAG_FRAC fraction bits.
  assign above = {1'b0, i_residual_voltage_magnitude} >
    {1'b0, (MAG_W)'({thr_ff, {MAG_FRAC{1'b0}}})};
  assign cond = (oper_ff == OPER_ON) && above;

  always_comb
  begin
    nxt_pre = '0;
    nxt_ms_cnt = '0;
    if (cond)
    begin
      nxt_ms_cnt = ms_cnt_ff;
      if (ms_cnt_ff < delay_ff)
      begin
        if (pre_ff == PRE_LAST)
          nxt_ms_cnt = ms_cnt_ff + 16'h0001;
        else
          nxt_pre = pre_ff + PRE_W'(1);
      end
    end
    nxt_state.start_raw = cond;
    nxt_state.trip_raw = cond && (nxt_ms_cnt >= delay_ff);
    nxt_state.gen_start = nxt_state.start_raw && !i_residual_ov_block_in;
    nxt_state.gen_trip = nxt_state.trip_raw && !i_residual_ov_block_in &&
      !start_only_ff;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pre_ff <= '0;
      ms_cnt_ff <= '0;
      state_ff <= STATE_RESET;
    end
    else
    begin
      pre_ff <= nxt_pre;
      ms_cnt_ff <= nxt_ms_cnt;
      state_ff <= nxt_state;
    end
  end

  assign o_residual_ov_start_raw = state_ff.start_raw;
  assign o_residual_ov_trip_raw = state_ff.trip_raw;
  assign o_residual_ov_general_start = state_ff.gen_start;
  assign o_residual_ov_general_trip = state_ff.gen_trip;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: rising general start and trip set sticky bits, write one clears.
  logic [IRQ_W-1:0] irq_st_ff, nxt_irq_st;
  logic [IRQ_W-1:0] irq_evt;
  logic irq_ff, nxt_irq;

  assign irq_evt[IRQ_START_BIT] = nxt_state.gen_start && !state_ff.gen_start;
  assign irq_evt[IRQ_TRIP_BIT] = nxt_state.gen_trip && !state_ff.gen_trip;

  always_comb
  begin
    nxt_irq_st = irq_st_ff;
    if (i_we && (i_addr == OFS_IRQ_STATUS))
      nxt_irq_st = irq_st_ff & ~i_wdata[IRQ_W-1:0];
    // A new event wins over a clear in the same cycle.
    nxt_irq_st = nxt_irq_st | irq_evt;
    nxt_irq = |(nxt_irq_st & nxt_irq_mask);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_st_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_st_ff <= nxt_irq_st;
      irq_ff <= nxt_irq;
    end
  end

  assign o_irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand in the cycle after the read strobe only.
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb
  begin
    nxt_rdata = '0;
    if (i_re)
    begin
      unique case (i_addr)
        OFS_CTRL:
        begin
          nxt_rdata[CTRL_OPER_BIT] = oper_ff;
          nxt_rdata[CTRL_START_ONLY_BIT] = start_only_ff;
        end
        OFS_THRESHOLD: nxt_rdata[THR_W-1:0] = thr_ff;
        OFS_DELAY: nxt_rdata[DELAY_W-1:0] = delay_ff;
        OFS_STATE: nxt_rdata[3:0] = state_ff;
        OFS_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = irq_st_ff;
        OFS_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_started;
    cond;
  endsequence

  sequence s_dropped;
    !cond;
  endsequence

  a_start_over_thr: assert property (s_started |=> state_ff.start_raw)
    else $error("start not raised above threshold");
  a_oper_off_quiet: assert property ((oper_ff == OPER_OFF) |=>
    !state_ff.start_raw && !state_ff.trip_raw)
    else $error("start or trip while operation off");
  a_drop_clears: assert property (s_dropped |=>
    !state_ff.start_raw && !state_ff.trip_raw && (ms_cnt_ff == '0))
    else $error("drop-off did not clear start and count");
  a_drop_general: assert property (s_dropped |=>
    !state_ff.gen_start && !state_ff.gen_trip)
    else $error("general output after drop-off");
  a_trip_not_early: assert property (state_ff.start_raw &&
    (ms_cnt_ff < delay_ff) && $stable(delay_ff) |-> !state_ff.trip_raw)
    else $error("trip before delay elapsed");
  a_trip_on_count: assert property (s_started |=>
    (state_ff.trip_raw == (ms_cnt_ff >= $past(delay_ff))))
    else $error("trip does not follow the delay count");
  a_zero_delay: assert property (s_started && (delay_ff == '0) |=>
    state_ff.trip_raw)
    else $error("zero delay did not trip at once");
  a_trip_needs_start: assert property (state_ff.trip_raw |-> state_ff.start_raw)
    else $error("trip without start");
  a_block_forces: assert property (i_residual_ov_block_in |=>
    !state_ff.gen_start && !state_ff.gen_trip)
    else $error("general output while blocked");
  a_start_only_gate: assert property (start_only_ff && $stable(start_only_ff) |->
    !state_ff.gen_trip)
    else $error("general trip in start-only mode");
  a_gen_start_src: assert property (state_ff.gen_start |-> state_ff.start_raw)
    else $error("general start without raw start");
  a_gen_start_free: assert property (!i_residual_ov_block_in |=>
    (state_ff.gen_start == state_ff.start_raw))
    else $error("unblocked general start differs from raw start");
  a_gen_trip_src: assert property ($rose(state_ff.gen_trip) |->
    state_ff.trip_raw && !$past(start_only_ff))
    else $error("general trip without cause");
  a_gen_trip_free: assert property (!i_residual_ov_block_in && !start_only_ff |=>
    (state_ff.gen_trip == state_ff.trip_raw))
    else $error("unblocked general trip differs from raw trip");
  a_thr_range: assert property ((thr_ff >= THR_MIN) && (thr_ff <= THR_MAX))
    else $error("threshold out of range");
  a_delay_range: assert property (delay_ff <= DELAY_MAX)
    else $error("delay out of range");
  a_ms_step: assert property (state_ff.start_raw && cond &&
    (ms_cnt_ff < delay_ff) |=> (ms_cnt_ff == $past(ms_cnt_ff)) ||
    (ms_cnt_ff == $past(ms_cnt_ff) + 16'h0001))
    else $error("delay count jumped");

  // Interrupt status and read port housekeeping.
  a_irq_event_sets: assert property ((|irq_evt) |=>
    ((irq_st_ff & $past(irq_evt)) == $past(irq_evt)))
    else $error("interrupt event lost");
  a_rdata_idle: assert property (!i_re |=> (o_rdata == '0))
    else $error("read data outside the read cycle");

endmodule

`default_nettype wire

//--- upstream_model.sv
// Purpose: Upstream residual magnitude source and user blocking logic.
// Assumes: Magnitude in percent of rated voltage with eight fraction bits.
// Notes: Slow mode ramps one percent per clock, as a settling filter would.
`default_nettype none

module upstream_model
  import residual_ov_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_target,
  input wire logic i_slow,
  input wire logic i_block_req,
  output logic [15:0] o_mag,
  output logic o_block
);
  logic [15:0] nxt_mag;
  logic [15:0] mag_ff;
  logic block_ff;

  ////////////////////////////////////////////////////////////////////////////
  // The residual magnitude either steps at once or ramps toward the target.
  always_comb
  begin
    nxt_mag = i_target;
    if (i_slow && (i_target > mag_ff + 16'h0100))
      nxt_mag = mag_ff + 16'h0100;
    else if (i_slow && (mag_ff > i_target + 16'h0100))
      nxt_mag = mag_ff - 16'h0100;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mag_ff <= 16'h0000;
      block_ff <= 1'b0;
    end
    else
    begin
      mag_ff <= nxt_mag;
      block_ff <= i_block_req;
    end
  end

  assign o_mag = mag_ff;
  assign o_block = block_ff;
endmodule

`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the residual overvoltage trip block.
// Assumes: One millisecond shortened to four clocks.
// Notes: Outputs are sampled on the falling edge, inputs driven on the rising edge.
`default_nettype none

`define chk(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module testbench
  import residual_ov_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, we, re, slow, blk_req, blk, start_raw, trip_raw, gen_start, gen_trip, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] target, mag;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  upstream_model src (.i_clk(clk), .i_rst(rst), .i_target(target), .i_slow(slow),
    .i_block_req(blk_req), .o_mag(mag), .o_block(blk));
  residual_overvoltage_trip #(.MAG_W(16), .CYC_PER_MS(4)) dut (.i_clk(clk), .i_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata),
    .i_residual_voltage_magnitude(mag), .i_residual_ov_block_in(blk),
    .o_residual_ov_start_raw(start_raw), .o_residual_ov_trip_raw(trip_raw),
    .o_residual_ov_general_start(gen_start), .o_residual_ov_general_trip(gen_trip),
    .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    `chk(rdata, exp)
  endtask

  task automatic drive(input logic [15:0] t, input logic s, input logic b, input int n);
    @(posedge clk);
    target <= t;
    slow <= s;
    blk_req <= b;
    repeat (n) @(negedge clk);
  endtask

  // Cycles from the start edge to the trip edge.
  task automatic trip_time(input int exp);
    int n;
    n = 0;
    while (start_raw !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (trip_raw !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    `chk(n, exp)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst = 1'b1;
    {addr, wdata, we, re, target, slow, blk_req} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFS_CTRL, 32'h0000_0001);
    rdchk(OFS_THRESHOLD, 32'h0000_001E);
    rdchk(OFS_DELAY, 32'h0000_0064);
    rdchk(8'h18, 32'h0000_0000);
    wr(OFS_THRESHOLD, 32'h0000_0001);
    rdchk(OFS_THRESHOLD, 32'h0000_0002);
    wr(OFS_THRESHOLD, 32'h0000_003D);
    rdchk(OFS_THRESHOLD, 32'h0000_003C);
    wr(OFS_DELAY, 32'h0000_EA61);
    rdchk(OFS_DELAY, 32'h0000_EA60);
    $display("test settings finished");
    wr(OFS_THRESHOLD, 32'h0000_001E);
    wr(OFS_DELAY, 32'h0000_0002);
    drive(16'h1E00, 1'b1, 1'b0, 40);
    `chk(start_raw, 1'b0)
    drive(16'h1E01, 1'b1, 1'b0, 0);
    // Start is registered one edge after the overvoltage appears, so trip follows it by 2*4-1.
    trip_time(7);
    `chk(gen_start, 1'b1)
    `chk(gen_trip, 1'b1)
    rdchk(OFS_STATE, 32'h0000_000F);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0003);
    `chk(irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    @(negedge clk);
    `chk(irq, 1'b1)
    wr(OFS_IRQ_STATUS, 32'h0000_0003);
    @(negedge clk);
    `chk(irq, 1'b0)
    $display("test delayed trip finished");
    drive(16'h1E01, 1'b0, 1'b1, 3);
    `chk(gen_start, 1'b0)
    `chk(gen_trip, 1'b0)
    `chk(start_raw, 1'b1)
    drive(16'h0000, 1'b0, 1'b0, 3);
    `chk(start_raw, 1'b0)
    `chk(trip_raw, 1'b0)
    drive(16'h1E01, 1'b0, 1'b0, 0);
    trip_time(7);
    $display("test block and drop-off finished");
    drive(16'h0000, 1'b0, 1'b0, 3);
    wr(OFS_CTRL, 32'h0000_0003);
    wr(OFS_DELAY, 32'h0000_0000);
    drive(16'h1E01, 1'b0, 1'b0, 0);
    trip_time(0);
    @(negedge clk);
    `chk(gen_trip, 1'b0)
    `chk(gen_start, 1'b1)
    wr(OFS_CTRL, 32'h0000_0000);
    repeat (2) @(negedge clk);
    `chk(start_raw, 1'b0)
    `chk(gen_start, 1'b0)
    $display("test start-only and off finished");
    tally_and_finish();
  end
endmodule

`undef chk
`default_nettype wire
